// ===== rtl/diag_serial_port.sv
`timescale 1ns/100ps
module diag_serial_port
    import xcvr_diag_pkg::*;
#(
    parameter int READ_W = 16
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              scl_in,
    input  wire logic              sda_in,
    output logic                   sda_out,
    output logic                   sda_oe,
    input  wire logic              no_light_flag,
    input  wire logic              id_write_protect,
    output logic                   signal_present,
    input  wire logic              cal_internal,
    input  wire logic [READ_W-1:0] temp_reading,
    input  wire logic [READ_W-1:0] vcc_reading,
    input  wire logic [READ_W-1:0] bias_reading,
    input  wire logic [READ_W-1:0] txpwr_reading,
    input  wire logic [READ_W-1:0] rxpwr_reading
);
    if (READ_W != 2 * BYTE_W)
        $error("readings must be two bytes wide");

    typedef struct packed {
        link_state_t                     st;
        logic [3:0]                      cnt;
        logic [7:0]                      shift;
        logic [7:0]                      tx;
        logic [7:0]                      ptr;
        logic                            is_diag;
        logic                            rw;
        logic                            oe;
        logic                            host_nack;
        logic                            scl_d;
        logic                            sda_d;
        logic                            sp;
        logic [FLAG_W-1:0]               alarm;
        logic [FLAG_W-1:0]               warn;
        logic [N_PARAM-1:0][READ_W-1:0]  snap;
    } port_state_t;

    port_state_t                     q;
    port_state_t                     d;
    logic [BYTE_W-1:0]               id_mem   [MAP_DEPTH];
    logic [BYTE_W-1:0]               diag_mem [MAP_DEPTH];
    logic [N_PARAM-1:0][READ_W-1:0]  live;
    logic [FLAG_W-1:0]               alarm_now;
    logic [FLAG_W-1:0]               warn_now;
    logic [3:0]                      sync_out;
    logic                            scl_s;
    logic                            sda_s;
    logic                            nl_s;
    logic                            wp_s;
    logic                            scl_rise;
    logic                            scl_fall;
    logic                            start;
    logic                            stop;
    logic                            addr_hit;
    logic                            wr_prot;
    logic                            mem_we;
    logic [BYTE_W-1:0]               wdata;
    logic [BYTE_W-1:0]               rd_byte;

    line_sync #(.W(4)) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d_in  ({scl_in, sda_in, no_light_flag, id_write_protect}),
        .d_out (sync_out)
    );
    assign {scl_s, sda_s, nl_s, wp_s} = sync_out;

    assign live = {rxpwr_reading, txpwr_reading, bias_reading, vcc_reading, temp_reading};

    // clock is only ever sampled, never driven
    assign scl_rise = scl_s & ~q.scl_d;
    assign scl_fall = ~scl_s & q.scl_d;
    assign start    = q.sda_d & ~sda_s & scl_s & q.scl_d;
    assign stop     = ~q.sda_d & sda_s & scl_s & q.scl_d;
    assign addr_hit = (q.shift[7:1] == ID_DEV_ADDR) || (q.shift[7:1] == DIAG_DEV_ADDR);
    assign wdata    = {q.shift[6:0], sda_s};

    // identification map is locked unless the protect strap is released
    always_comb
    begin
        if (!q.is_diag)
            wr_prot = wp_s;
        else
            wr_prot = !((q.ptr <= THR_END) || (q.ptr >= USER_BASE) || (q.ptr == PIN_STATE_IDX));
    end

    // declared ahead of the per-value checks so they share clock and reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // thresholds per value: alarm high, alarm low, warn high, warn low
    for (genvar g = 0; g < N_PARAM; g++)
    begin : g_mon
        logic [READ_W-1:0] ah;
        logic [READ_W-1:0] al;
        logic [READ_W-1:0] wh;
        logic [READ_W-1:0] wl;
        assign ah = {diag_mem[THR_STRIDE*g],     diag_mem[THR_STRIDE*g + 1]};
        assign al = {diag_mem[THR_STRIDE*g + 2], diag_mem[THR_STRIDE*g + 3]};
        assign wh = {diag_mem[THR_STRIDE*g + 4], diag_mem[THR_STRIDE*g + 5]};
        assign wl = {diag_mem[THR_STRIDE*g + 6], diag_mem[THR_STRIDE*g + 7]};
        // compares are unsigned; signed temperature needs offset coding
        assign alarm_now[FLAG_W-1-2*g] = live[g] > ah;
        assign alarm_now[FLAG_W-2-2*g] = live[g] < al;
        assign warn_now[FLAG_W-1-2*g]  = live[g] > wh;
        assign warn_now[FLAG_W-2-2*g]  = live[g] < wl;

        chk_alarm_high: assert property (live[g] > ah |=> q.alarm[FLAG_W-1-2*g])
            else $error("alarm high flag not set");
    end
    assign alarm_now[FLAG_W-2*N_PARAM-1:0] = '0;
    assign warn_now[FLAG_W-2*N_PARAM-1:0]  = '0;

    always_comb
    begin
        rd_byte = diag_mem[q.ptr];
        if (!q.is_diag)
            rd_byte = id_mem[q.ptr];
        else
        begin
            for (int i = 0; i < N_PARAM; i++)
            begin
                if (q.ptr == RD_BASE + 8'(2*i))
                    rd_byte = q.snap[i][READ_W-1:BYTE_W];
                if (q.ptr == RD_BASE + 8'(2*i + 1))
                    rd_byte = q.snap[i][BYTE_W-1:0];
            end
            case (q.ptr)
                PIN_STATE_IDX: rd_byte[SP_BIT] = q.sp;
                CAL_IDX:
                begin
                    rd_byte[CAL_INT_BIT] = cal_internal;
                    rd_byte[CAL_EXT_BIT] = ~cal_internal;
                end
                ALARM_HI_IDX:  rd_byte = q.alarm[FLAG_W-1:BYTE_W];
                ALARM_LO_IDX:  rd_byte = q.alarm[BYTE_W-1:0];
                WARN_HI_IDX:   rd_byte = q.warn[FLAG_W-1:BYTE_W];
                WARN_LO_IDX:   rd_byte = q.warn[BYTE_W-1:0];
                default:       ;
            endcase
        end
    end

    always_comb
    begin
        d       = q;
        d.scl_d = scl_s;
        d.sda_d = sda_s;
        d.sp    = ~nl_s;
        d.alarm = alarm_now;
        d.warn  = warn_now;
        mem_we  = 1'b0;
        if (stop)
        begin
            d.st = ST_IDLE;
            d.oe = 1'b0;
        end
        else if (start)
        begin
            d.st   = ST_ADDR;
            d.cnt  = 4'h0;
            d.oe   = 1'b0;
            // snapshot keeps the two bytes of a reading coherent
            d.snap = live;
        end
        else if (scl_rise)
        begin
            d.shift = wdata;
            d.cnt   = q.cnt + 4'h1;
            if (q.st == ST_WR && q.cnt == BIT_LAST && !wr_prot)
                mem_we = 1'b1;
            if (q.st == ST_RACK)
                d.host_nack = sda_s;
        end
        else if (scl_fall)
        begin
            case (q.st)
                ST_ADDR:
                    if (q.cnt == BITS)
                    begin
                        if (addr_hit)
                        begin
                            d.is_diag = q.shift[1];
                            d.rw      = q.shift[0];
                            d.oe      = 1'b1;
                            d.st      = ST_ACK_ADR;
                        end
                        else
                            d.st = ST_IDLE;
                    end
                ST_ACK_ADR, ST_RACK:
                begin
                    d.cnt = 4'h0;
                    if (q.st == ST_RACK && q.host_nack)
                    begin
                        d.oe = 1'b0;
                        d.st = ST_IDLE;
                    end
                    else if (q.st == ST_RACK || q.rw)
                    begin
                        d.st = ST_RD;
                        d.oe = ~rd_byte[BYTE_W-1];
                        d.tx = {rd_byte[BYTE_W-2:0], 1'b0};
                    end
                    else
                    begin
                        d.st = ST_PTR;
                        d.oe = 1'b0;
                    end
                end
                ST_PTR:
                    if (q.cnt == BITS)
                    begin
                        d.ptr = q.shift;
                        d.oe  = 1'b1;
                        d.st  = ST_ACK_PTR;
                    end
                ST_ACK_PTR, ST_ACK_WR:
                begin
                    d.oe  = 1'b0;
                    d.cnt = 4'h0;
                    d.st  = ST_WR;
                end
                ST_WR:
                    if (q.cnt == BITS)
                    begin
                        d.ptr = q.ptr + 8'h01;
                        d.oe  = 1'b1;
                        d.st  = ST_ACK_WR;
                    end
                ST_RD:
                    if (q.cnt == BITS)
                    begin
                        d.oe  = 1'b0;
                        d.ptr = q.ptr + 8'h01;
                        d.st  = ST_RACK;
                    end
                    else
                    begin
                        d.oe = ~q.tx[BYTE_W-1];
                        d.tx = {q.tx[BYTE_W-2:0], 1'b0};
                    end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            q    <= '0;
            q.st <= ST_IDLE;
            q.sp <= 1'b1;
        end
        else
            q <= d;
    end

    // maps carry no reset; contents survive a bus reset
    always_ff @(posedge clk)
    begin
        if (mem_we)
        begin
            if (q.is_diag)
                diag_mem[q.ptr] <= wdata;
            else
                id_mem[q.ptr] <= wdata;
        end
    end

    // open drain: only ever pulls low
    assign sda_out        = 1'b0;
    assign sda_oe         = q.oe;
    assign signal_present = q.sp;

    chk_sp_follow: assert property ($rose(nl_s) |=> !signal_present ##1 !signal_present || $rose(nl_s))
        else $error("signal present did not drop on loss of light");
    chk_pin_byte: assert property (q.is_diag && q.ptr == PIN_STATE_IDX |-> rd_byte[SP_BIT] == signal_present)
        else $error("byte 110 bit 1 differs from signal present");
    chk_foreign_addr: assert property (scl_fall && !start && !stop && q.st == ST_ADDR && q.cnt == BITS
        && !addr_hit |=> !sda_oe && q.st == ST_IDLE)
        else $error("foreign address not released");
    chk_id_select: assert property (scl_fall && !start && !stop && q.st == ST_ADDR && q.cnt == BITS
        && addr_hit && !q.shift[1] |=> sda_oe && !q.is_diag)
        else $error("identification address not acknowledged");
    chk_diag_select: assert property (scl_fall && !start && !stop && q.st == ST_ADDR && q.cnt == BITS
        && addr_hit && q.shift[1] |=> sda_oe && q.is_diag)
        else $error("diagnostic address not acknowledged");
    chk_oe_on_fall: assert property ($changed(sda_oe) |-> $past(scl_fall || start || stop))
        else $error("data line changed outside a clock fall");
    chk_write_guard: assert property (mem_we |-> !wr_prot && q.st == ST_WR && scl_rise)
        else $error("write into protected area or off the clock rise");
    chk_ptr_step: assert property (scl_fall && !start && !stop && q.cnt == BITS
        && (q.st == ST_RD || q.st == ST_WR) |=> q.ptr == $past(q.ptr) + 8'h01)
        else $error("pointer did not advance by one");
    chk_read_bits: assert property (q.st == ST_RD |-> q.cnt <= BITS)
        else $error("read byte longer than eight bits");
    chk_live_read: assert property (q.is_diag && q.ptr == RD_BASE |-> rd_byte == q.snap[0][READ_W-1:BYTE_W])
        else $error("temperature reading not returned");
    chk_cal_mode: assert property (q.is_diag && q.ptr == CAL_IDX |-> rd_byte[CAL_INT_BIT] == cal_internal
        && rd_byte[CAL_EXT_BIT] != cal_internal)
        else $error("calibration mode bits wrong");
endmodule // diag_serial_port

// ===== rtl/xcvr_diag_pkg.sv
package xcvr_diag_pkg;

    // 7-bit bus addresses: identification map and diagnostic map
    localparam logic [6:0] ID_DEV_ADDR   = 7'h50;
    localparam logic [6:0] DIAG_DEV_ADDR = 7'h51;

    localparam int         BYTE_W    = 8;
    localparam int         MAP_DEPTH = 256;
    localparam logic [3:0] BITS      = 4'h8;
    localparam logic [3:0] BIT_LAST  = 4'h7;

    // diagnostic map layout
    localparam logic [7:0] THR_END       = 8'h27;
    localparam int         THR_STRIDE    = 8;
    localparam logic [7:0] CAL_IDX       = 8'h5c;
    localparam int         CAL_INT_BIT   = 5;
    localparam int         CAL_EXT_BIT   = 4;
    localparam logic [7:0] RD_BASE       = 8'h60;
    localparam logic [7:0] PIN_STATE_IDX = 8'h6e;
    localparam int         SP_BIT        = 1;
    localparam logic [7:0] ALARM_HI_IDX  = 8'h70;
    localparam logic [7:0] ALARM_LO_IDX  = 8'h71;
    localparam logic [7:0] WARN_HI_IDX   = 8'h74;
    localparam logic [7:0] WARN_LO_IDX   = 8'h75;
    localparam logic [7:0] USER_BASE     = 8'h80;

    // monitored values: temperature, supply, bias, tx power, rx power
    localparam int N_PARAM = 5;
    localparam int FLAG_W  = 16;

    typedef enum logic [8:0] {
        ST_IDLE    = 9'h001,
        ST_ADDR    = 9'h002,
        ST_ACK_ADR = 9'h004,
        ST_PTR     = 9'h008,
        ST_ACK_PTR = 9'h010,
        ST_WR      = 9'h020,
        ST_ACK_WR  = 9'h040,
        ST_RD      = 9'h080,
        ST_RACK    = 9'h100
    } link_state_t;

endpackage

// ===== rtl/line_sync.sv
`timescale 1ns/100ps
module line_sync #(
    parameter int W = 4
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] d_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_t;

    sync_t q;
    sync_t d;

    always_comb
    begin
        d    = q;
        d.s1 = d_in;
        d.s2 = q.s1;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            q <= '0;
        else
            q <= d;
    end

    assign d_out = q.s2;
endmodule // line_sync

// ===== verification/host_bus_model.sv
`timescale 1ns/100ps
module host_bus_model (
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_pull
);
    // clock idles high and stands still between frames
    initial
    begin
        scl      = 1'b1;
        sda_pull = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask

    // data set mid low phase, sampled at the end of the high phase
    task automatic bit_xfer(input logic b, output logic s);
        sda_pull <= ~b;
        wait_clk(2);
        scl <= 1'b1;
        wait_clk(4);
        s = sda;
        scl <= 1'b0;
        wait_clk(2);
    endtask

    // works from idle and as a repeated start
    task automatic start();
        sda_pull <= 1'b0;
        wait_clk(2);
        scl <= 1'b1;
        wait_clk(4);
        sda_pull <= 1'b1;
        wait_clk(4);
        scl <= 1'b0;
        wait_clk(2);
    endtask

    task automatic stop();
        sda_pull <= 1'b1;
        wait_clk(2);
        scl <= 1'b1;
        wait_clk(4);
        sda_pull <= 1'b0;
        wait_clk(4);
    endtask

    task automatic wbyte(input logic [7:0] b, output logic ack_n);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_xfer(b[i], s);
        bit_xfer(1'b1, ack_n);
    endtask

    task automatic rbyte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_xfer(1'b1, b[i]);
        bit_xfer(last, s);
    endtask
endmodule // host_bus_model

// ===== verification/transceiver_diag_serial_port_test.sv
`timescale 1ns/100ps
`define CHK(what, exp, got) \
    begin \
        check_count++; \
        if ((got) !== (exp)) \
        begin \
            err_total++; \
            $display("BAD %s expected %h seen %h", what, exp, got); \
        end \
    end
module transceiver_diag_serial_port_test import xcvr_diag_pkg::*;;
    logic        clk;
    logic        rst_n;
    logic        no_light;
    logic        wp;
    logic        cal;
    logic [15:0] rdg [5];
    logic        scl;
    logic        pull;
    logic        sda_out;
    logic        sda_oe;
    logic        sp;
    int          err_total;
    int          check_count;
    // open drain line with pull-up
    wire         sda = ~(pull | (sda_oe & ~sda_out));

    diag_serial_port i_dut (
        .clk              (clk),
        .rst_n            (rst_n),
        .scl_in           (scl),
        .sda_in           (sda),
        .sda_out          (sda_out),
        .sda_oe           (sda_oe),
        .no_light_flag    (no_light),
        .id_write_protect (wp),
        .signal_present   (sp),
        .cal_internal     (cal),
        .temp_reading     (rdg[0]),
        .vcc_reading      (rdg[1]),
        .bias_reading     (rdg[2]),
        .txpwr_reading    (rdg[3]),
        .rxpwr_reading    (rdg[4])
    );

    host_bus_model i_host (
        .clk      (clk),
        .sda      (sda),
        .scl      (scl),
        .sda_pull (pull)
    );

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic rd(input logic [6:0] dev, input logic [7:0] ptr,
                      output logic [7:0] r0, output logic [7:0] r1);
        logic a;
        i_host.start();
        i_host.wbyte({dev, 1'b0}, a);
        `CHK("addr ack", 1'b0, a)
        i_host.wbyte(ptr, a);
        i_host.start();
        i_host.wbyte({dev, 1'b1}, a);
        `CHK("read addr ack", 1'b0, a)
        i_host.rbyte(1'b0, r0);
        i_host.rbyte(1'b1, r1);
        i_host.stop();
    endtask

    task automatic wr(input logic [6:0] dev, input logic [7:0] ptr,
                      input logic [7:0] d0, input logic [7:0] d1);
        logic       a;
        logic [7:0] b [3];
        b = '{ptr, d0, d1};
        i_host.start();
        i_host.wbyte({dev, 1'b0}, a);
        `CHK("addr ack", 1'b0, a)
        foreach (b[k])
        begin
            i_host.wbyte(b[k], a);
            `CHK("byte ack", 1'b0, a)
        end
        i_host.stop();
    endtask

    task automatic t_pin();
        logic [7:0] r0;
        logic [7:0] r1;
        for (int i = 0; i < 2; i++)
        begin
            no_light <= ~i[0];
            repeat (8) @(posedge clk);
            `CHK("signal present", i[0], sp)
            rd(DIAG_DEV_ADDR, PIN_STATE_IDX, r0, r1);
            `CHK("pin state bit", i[0], r0[SP_BIT])
        end
        $display("t_pin done");
    endtask

    // writes cross 0xff so the shared pointer must wrap
    task automatic t_maps();
        logic [7:0] r0;
        logic [7:0] r1;
        wp <= 1'b0;
        wr(ID_DEV_ADDR, 8'hff, 8'h5a, 8'hc3);
        wr(DIAG_DEV_ADDR, 8'hff, 8'ha5, 8'h3c);
        rd(DIAG_DEV_ADDR, 8'hff, r0, r1);
        `CHK("diag data", 16'ha53c, {r0, r1})
        rd(ID_DEV_ADDR, 8'hff, r0, r1);
        `CHK("id data", 16'h5ac3, {r0, r1})
        wp <= 1'b1;
        wr(ID_DEV_ADDR, 8'hff, 8'h11, 8'h22);
        rd(ID_DEV_ADDR, 8'hff, r0, r1);
        `CHK("protected id", 16'h5ac3, {r0, r1})
        $display("t_maps done");
    endtask

    task automatic t_nack();
        logic a;
        i_host.start();
        i_host.wbyte({7'h52, 1'b0}, a);
        `CHK("foreign addr ack", 1'b1, a)
        i_host.stop();
        $display("t_nack done");
    endtask

    task automatic t_mon();
        logic [7:0]  r0;
        logic [7:0]  r1;
        logic [15:0] e;
        for (int i = 0; i < N_PARAM; i++)
        begin
            e = {i[7:0] + 8'h10, ~i[7:0]};
            rdg[i] <= e;
            rd(DIAG_DEV_ADDR, RD_BASE + 8'(2 * i), r0, r1);
            `CHK("reading", e, {r0, r1})
        end
        for (int c = 0; c < 2; c++)
        begin
            cal <= c[0];
            rd(DIAG_DEV_ADDR, CAL_IDX, r0, r1);
            `CHK("cal mode", {c[0], ~c[0]}, {r0[CAL_INT_BIT], r0[CAL_EXT_BIT]})
        end
        $display("t_mon done");
    endtask

    // only the temperature high alarm bit is judged; other limits unset
    task automatic t_alarm();
        logic [7:0] r0;
        logic [7:0] r1;
        wr(DIAG_DEV_ADDR, 8'h00, 8'h10, 8'h00);
        for (int k = 0; k < 2; k++)
        begin
            rdg[0] <= k[0] ? 16'h1234 : 16'h0800;
            rd(DIAG_DEV_ADDR, ALARM_HI_IDX, r0, r1);
            `CHK("temp high alarm", k[0], r0[7])
        end
        $display("t_alarm done");
    endtask

    initial
    begin
        rst_n = 1'b0;
        no_light = 1'b0;
        wp = 1'b0;
        cal = 1'b0;
        err_total = 0;
        check_count = 0;
        foreach (rdg[i])
            rdg[i] = 16'h0000;
        repeat (12) @(posedge clk);
        `CHK("oe in reset", 1'b0, sda_oe)
        `CHK("sda drive level", 1'b0, sda_out)
        `CHK("sp in reset", 1'b1, sp)
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_pin();
        t_maps();
        t_nack();
        t_mon();
        t_alarm();
        complete_run();
    end

    initial
    begin
        repeat (40000) @(posedge clk);
        err_total++;
        complete_run();
    end
endmodule // transceiver_diag_serial_port_test
